// >>> include/cal_pkg.sv
// Purpose: Shared constants, types and helpers of the cell converter control block.
// Assumes: 250 MHz system clock, byte-wide register port.
// Notes: All register offsets and field positions live here.
`default_nettype none
package cal_pkg;
    // ********************************************
    // Sizes
    // ********************************************
    localparam int NCH = 6;
    localparam int RAW_W = 24;
    localparam int CORR_W = 16;
    localparam int FRAC_W = 8;
    localparam int TALLY_W = 14;
    localparam int TMR_W = 20;
    localparam int TC_SHIFT = 12;
    localparam int LP_BASE_SHIFT = 1;
    // ********************************************
    // Timing
    // ********************************************
    localparam int CLK_MHZ = 250;
    localparam int DLY_STEP_NS = 1000;
    localparam int DLY_STEP_CYC = (DLY_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int INT_STEP_NS = 100000;
    localparam int INT_STEP_CYC = (INT_STEP_NS * CLK_MHZ + 999) / 1000;
    // ********************************************
    // Register map
    // ********************************************
    localparam logic [7:0] ADR_CONFIG_A = 8'h00;
    localparam logic [7:0] ADR_CONFIG_B = 8'h01;
    localparam logic [7:0] ADR_CHAN_EN = 8'h02;
    localparam logic [7:0] ADR_TRIGGER = 8'h03;
    localparam logic [7:0] ADR_DELAY = 8'h04;
    localparam logic [7:0] ADR_DIAG = 8'h05;
    localparam logic [7:0] ADR_STATUS = 8'h06;
    localparam logic [7:0] ADR_TALLY_H = 8'h07;
    localparam logic [7:0] ADR_TALLY_L = 8'h08;
    localparam logic [7:0] ADR_TCOEF = 8'h09;
    localparam logic [7:0] ADR_RES_BASE = 8'h10;
    localparam logic [7:0] ADR_RES_END = 8'h40;
    localparam logic [2:0] OFS_H = 3'h0;
    localparam logic [2:0] OFS_L = 3'h1;
    localparam logic [2:0] OFS_HF = 3'h2;
    localparam logic [2:0] OFS_LF = 3'h3;
    localparam logic [2:0] OFS_HU = 3'h4;
    localparam logic [2:0] OFS_MU = 3'h5;
    localparam logic [2:0] OFS_LU = 3'h6;
    // Field positions.
    localparam int DECIM_LSB = 0;
    localparam int CORNER_LSB = 2;
    localparam int REPEAT_BIT = 0;
    localparam int INTERVAL_LSB = 1;
    localparam int TRIG_BIT = 0;
    localparam int FSRC_BIT = 0;
    localparam int RAWF_BIT = 1;
    localparam int ACTIVE_BIT = 0;
    localparam int VALID_BIT = 1;
    // Reset and marker values.
    localparam logic [7:0] CONFIG_A_RST = 8'h00;
    localparam logic [7:0] CONFIG_B_RST = 8'h00;
    localparam logic [5:0] CHAN_EN_RST = 6'h00;
    localparam logic [4:0] DELAY_RST = 5'h00;
    localparam logic [7:0] TCOEF_RST = 8'h00;
    localparam logic [15:0] MARK16 = 16'h8000;
    localparam logic [23:0] MARK24 = 24'h800000;
    // ********************************************
    // Types and helpers
    // ********************************************
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_DELAY = 2'b01,
        CAL_CONV = 2'b11,
        CAL_GAP = 2'b10
    } cal_state_t;

    // Die temperature correction; a raw count is 1/256 of a corrected count.
    function automatic logic [CORR_W-1:0] cal_correct(input logic [RAW_W-1:0] raw,
                                                      input logic [CORR_W-1:0] temp,
                                                      input logic [7:0] coef);
        logic signed [RAW_W-1:0] t;
        logic signed [RAW_W-1:0] c;
        logic signed [RAW_W-1:0] prod;
        t = RAW_W'($signed(temp));
        c = RAW_W'($signed(coef));
        prod = t * c;
        return raw[RAW_W-1:RAW_W-CORR_W] + CORR_W'(prod >>> TC_SHIFT);
    endfunction : cal_correct
endpackage : cal_pkg
`default_nettype wire

// >>> include/cal_timer_if.sv
// Purpose: Load and expiry signals between the sequencer and its timer.
// Assumes: Single clock domain.
// Notes: A load of N expires N cycles later.
`timescale 1ns/100ps
`default_nettype none
interface cal_timer_if import cal_pkg::*; ();
    logic load;
    logic [TMR_W-1:0] count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : cal_timer_if
`default_nettype wire

// >>> rtl/cal_conv_timer.sv
// Purpose: Down counter for the trigger delay and the repeat interval.
// Assumes: Loads never carry zero.
// Notes: Done is high in the cycle the count reaches one.
`timescale 1ns/100ps
`default_nettype none
module cal_conv_timer import cal_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    cal_timer_if.tmr t
);
    logic [TMR_W-1:0] cnt_reg;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            cnt_reg <= '0;
        else if (t.load)
            cnt_reg <= t.count;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - TMR_W'(1);
    end

    assign t.done = (cnt_reg == TMR_W'(1)) && !t.load;
endmodule : cal_conv_timer
`default_nettype wire

// >>> rtl/cal_lowpass.sv
// Purpose: Single-pole low-pass filter for one channel.
// Assumes: One sample per completed conversion.
// Notes: The state starts at zero, so a fresh run shows an RC-like step.
`timescale 1ns/100ps
`default_nettype none
module cal_lowpass import cal_pkg::*; #(
    parameter int W = RAW_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Samples
    input wire logic sample_valid_in,
    input wire logic [W-1:0] sample_in,
    input wire logic [2:0] corner_sel_in,
    // Output
    output logic [W-1:0] lp_out,
    output logic lp_valid_out
);
    logic signed [W+FRAC_W-1:0] acc_reg;
    logic signed [W+FRAC_W:0] diff;
    logic [3:0] shift;

    always_comb
    begin
        shift = 4'(corner_sel_in) + 4'(LP_BASE_SHIFT);
        diff = $signed({sample_in[W-1], sample_in, FRAC_W'(0)}) - (W + FRAC_W + 1)'(acc_reg);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            acc_reg <= '0;
        else if (sample_valid_in)
            acc_reg <= acc_reg + (W + FRAC_W)'(diff >>> shift);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            lp_valid_out <= 1'b0;
        else
            lp_valid_out <= sample_valid_in;
    end

    assign lp_out = acc_reg[W+FRAC_W-1:FRAC_W];
endmodule : cal_lowpass
`default_nettype wire

// >>> rtl/cal_top.sv
// Purpose: Control and result logic of six simultaneous cell converters.
// Assumes: Converter samples and die temperature arrive on clk_in.
// Notes: Registers are bytes on a plain strobe port.
// Function
// - Three-bit selector sets low-pass corner; higher code halves it.
// - Low-pass acts like an RC stage with a step response.
// - Corrected results are 16 bits in two bytes; raw ones 24 in three.
// - Reading a high byte freezes lower bytes of that value.
// - Die temperature corrects each result; raw and corrected both kept.
// - Filtered corrected kept apart; raw shows filtered when both diag bits set.
// - Corrected count is 190.7349 uV, raw count 0.745 uV.
// - All results are two's complement.
// - Every trigger presets results to 0x8000 and 0x800000.
// - Channel enable powers its level shifter until cleared.
// - Trigger write starts conversion after optional delay.
// - In repeat mode wait the interval, then convert again.
// - Results-valid sets after first set, clears on next trigger.
// - Fourteen-bit tally counts repeat-mode conversions.
// - Clear repeat then trigger gives one last conversion.
// - Config and enable writes ignored while repeating, except the repeat bit.
// - Newest results presented after high byte read.
// - Active status high while converters run.
// - Trigger during conversion abandons it and restarts.
// - Die temperature converter shares the decimation setting.
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module cal_top import cal_pkg::*; #(
    parameter int DLY_STEP = DLY_STEP_CYC,
    parameter int INT_STEP = INT_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // Converter side
    input wire logic sample_valid_in,
    input wire logic [NCH*RAW_W-1:0] raw_sample_in,
    input wire logic [CORR_W-1:0] die_temp_in,
    output logic conv_start_out,
    output logic conv_run_out,
    output logic [NCH-1:0] level_shift_en_out,
    output logic [1:0] cell_decim_out,
    output logic [1:0] temp_decim_out
);
    // ********************************************
    // Declarations
    // ********************************************
    cal_state_t state_reg, state_next;
    logic [7:0] config_a_reg;
    logic [7:0] config_b_reg;
    logic [NCH-1:0] chan_en_reg;
    logic [4:0] delay_reg;
    logic [1:0] diag_reg;
    logic [7:0] tcoef_reg;
    logic rep_run_reg;
    logic valid_reg;
    logic [TALLY_W-1:0] tally_reg;
    logic [15:0] shadow_reg;
    logic [7:0] rd_data_reg;
    logic start_reg;
    logic run_reg;
    logic [CORR_W-1:0] corr_res_reg [NCH];
    logic [CORR_W-1:0] filt_res_reg [NCH];
    logic [RAW_W-1:0] raw_res_reg [NCH];
    logic [RAW_W-1:0] lp_y [NCH];
    logic lp_vld [NCH];
    logic trig_wr;
    logic locked;
    logic done_evt;
    logic raw_filtered;
    logic res_hit;
    logic [2:0] res_ch;
    logic [2:0] res_ofs;
    logic [7:0] res_rel;

    cal_timer_if tmr_if ();

    cal_conv_timer u_timer (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .t (tmr_if.tmr)
    );

    assign trig_wr = wr_in && (addr_in == ADR_TRIGGER) && wr_data_in[TRIG_BIT];
    assign locked = rep_run_reg && (state_reg != CAL_IDLE);
    assign done_evt = sample_valid_in && (state_reg == CAL_CONV) && !trig_wr;
    assign raw_filtered = diag_reg[FSRC_BIT] && diag_reg[RAWF_BIT];
    assign res_rel = addr_in - ADR_RES_BASE;
    assign res_ch = res_rel[5:3];
    assign res_ofs = res_rel[2:0];
    assign res_hit = (addr_in >= ADR_RES_BASE) && (addr_in < ADR_RES_END)
                     && (32'(res_ch) < NCH);

    // ********************************************
    // Configuration registers
    // ********************************************
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            config_a_reg <= CONFIG_A_RST;
            config_b_reg <= CONFIG_B_RST;
            chan_en_reg <= CHAN_EN_RST;
        end
        else if (!locked)
        begin
            if (wr_in && addr_in == ADR_CONFIG_A)
                config_a_reg <= wr_data_in;
            if (wr_in && addr_in == ADR_CONFIG_B)
                config_b_reg <= wr_data_in;
            if (wr_in && addr_in == ADR_CHAN_EN)
                chan_en_reg <= wr_data_in[NCH-1:0];
        end
        // repeat bit stays writable to stop
        else if (wr_in && addr_in == ADR_CONFIG_B)
            config_b_reg[REPEAT_BIT] <= wr_data_in[REPEAT_BIT];
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            delay_reg <= DELAY_RST;
            diag_reg <= '0;
            tcoef_reg <= TCOEF_RST;
        end
        else if (wr_in)
        begin
            if (addr_in == ADR_DELAY)
                delay_reg <= wr_data_in[4:0];
            if (addr_in == ADR_DIAG)
                diag_reg <= wr_data_in[1:0];
            if (addr_in == ADR_TCOEF)
                tcoef_reg <= wr_data_in;
        end
    end

    // ********************************************
    // Conversion sequencer
    // ********************************************
    always_comb
    begin
        state_next = state_reg;
        tmr_if.load = 1'b0;
        tmr_if.count = '0;
        if (trig_wr)
        begin
            if (delay_reg == '0)
                state_next = CAL_CONV;
            else
            begin
                state_next = CAL_DELAY;
                tmr_if.load = 1'b1;
                tmr_if.count = TMR_W'(32'(delay_reg) * DLY_STEP);
            end
        end
        else
        begin
            case (state_reg)
                CAL_DELAY:
                    if (tmr_if.done)
                        state_next = CAL_CONV;
                CAL_CONV:
                    if (done_evt)
                    begin
                        if (rep_run_reg)
                        begin
                            state_next = CAL_GAP;
                            tmr_if.load = 1'b1;
                            tmr_if.count = TMR_W'((32'(config_b_reg[INTERVAL_LSB+:3]) + 1)
                                                  * INT_STEP);
                        end
                        else
                            state_next = CAL_IDLE;
                    end
                CAL_GAP:
                    if (tmr_if.done)
                        state_next = CAL_CONV;
                default:
                    state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_reg <= CAL_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rep_run_reg <= 1'b0;
        else if (trig_wr)
            rep_run_reg <= config_b_reg[REPEAT_BIT];
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            run_reg <= 1'b0;
            start_reg <= 1'b0;
        end
        else
        begin
            run_reg <= (state_next == CAL_CONV);
            start_reg <= (state_next == CAL_CONV) && (state_reg != CAL_CONV || trig_wr);
        end
    end

    // set on completion, clear on trigger
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            valid_reg <= 1'b0;
        else if (done_evt)
            valid_reg <= 1'b1;
        else if (trig_wr)
            valid_reg <= 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            tally_reg <= '0;
        else if (done_evt && rep_run_reg)
            tally_reg <= tally_reg + TALLY_W'(1);
    end

    // ********************************************
    // Results
    // ********************************************
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        logic [RAW_W-1:0] raw_s;
        logic [CORR_W-1:0] corr_s;
        assign raw_s = raw_sample_in[i*RAW_W+:RAW_W];
        assign corr_s = cal_correct(raw_s, die_temp_in, tcoef_reg);

        cal_lowpass #(.W(RAW_W)) u_lp (
            .clk_in (clk_in),
            .rst_in (rst_in),
            .sample_valid_in (done_evt && chan_en_reg[i]),
            .sample_in (diag_reg[FSRC_BIT] ? raw_s : {corr_s, FRAC_W'(0)}),
            .corner_sel_in (config_a_reg[CORNER_LSB+:3]),
            .lp_out (lp_y[i]),
            .lp_valid_out (lp_vld[i])
        );

        always_ff @(posedge clk_in)
        begin
            if (rst_in || trig_wr)
            begin
                corr_res_reg[i] <= MARK16;
                filt_res_reg[i] <= MARK16;
                raw_res_reg[i] <= MARK24;
            end
            else
            begin
                if (done_evt && chan_en_reg[i])
                    corr_res_reg[i] <= corr_s;
                // raw view carries filter output only with both bits
                if (done_evt && chan_en_reg[i] && !raw_filtered)
                    raw_res_reg[i] <= raw_s;
                else if (lp_vld[i] && raw_filtered)
                    raw_res_reg[i] <= lp_y[i];
                if (lp_vld[i])
                    filt_res_reg[i] <= lp_y[i][RAW_W-1:RAW_W-CORR_W];
            end
        end
    end

    // ********************************************
    // Read port
    // ********************************************
    // high byte read freezes lower bytes
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            shadow_reg <= '0;
        else if (rd_in && addr_in == ADR_TALLY_H)
            shadow_reg <= {8'h00, tally_reg[7:0]};
        else if (rd_in && res_hit)
        begin
            case (res_ofs)
                OFS_H: shadow_reg <= {8'h00, corr_res_reg[res_ch][7:0]};
                OFS_HF: shadow_reg <= {8'h00, filt_res_reg[res_ch][7:0]};
                OFS_HU: shadow_reg <= raw_res_reg[res_ch][15:0];
                default: shadow_reg <= shadow_reg;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in || !rd_in)
            rd_data_reg <= 8'h00;
        else if (res_hit)
        begin
            case (res_ofs)
                OFS_H: rd_data_reg <= corr_res_reg[res_ch][15:8];
                OFS_HF: rd_data_reg <= filt_res_reg[res_ch][15:8];
                OFS_HU: rd_data_reg <= raw_res_reg[res_ch][23:16];
                OFS_MU: rd_data_reg <= shadow_reg[15:8];
                OFS_L, OFS_LF, OFS_LU: rd_data_reg <= shadow_reg[7:0];
                default: rd_data_reg <= 8'h00;
            endcase
        end
        else
        begin
            case (addr_in)
                ADR_CONFIG_A: rd_data_reg <= config_a_reg;
                ADR_CONFIG_B: rd_data_reg <= config_b_reg;
                ADR_CHAN_EN: rd_data_reg <= 8'(chan_en_reg);
                ADR_DELAY: rd_data_reg <= 8'(delay_reg);
                ADR_DIAG: rd_data_reg <= 8'(diag_reg);
                ADR_STATUS: rd_data_reg <= 8'({valid_reg, run_reg});
                ADR_TALLY_H: rd_data_reg <= 8'(tally_reg[TALLY_W-1:8]);
                ADR_TALLY_L: rd_data_reg <= shadow_reg[7:0];
                ADR_TCOEF: rd_data_reg <= tcoef_reg;
                default: rd_data_reg <= 8'h00;
            endcase
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    assign rd_data_out = rd_data_reg;
    assign conv_start_out = start_reg;
    assign conv_run_out = run_reg;
    assign level_shift_en_out = chan_en_reg;
    assign cell_decim_out = config_a_reg[DECIM_LSB+:2];
    assign temp_decim_out = config_a_reg[DECIM_LSB+:2];
endmodule : cal_top
`default_nettype wire

// >>> tb/cal_top_sva.sv
// Purpose: Port-level assertions for the cell converter control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Shadows the delay register so that a zero-delay trigger can be checked for a start on the next edge.
`timescale 1ns/100ps
`default_nettype none
module cal_top_sva import cal_pkg::*; #(
    parameter int DLY_STEP = DLY_STEP_CYC,
    parameter int INT_STEP = INT_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    // Converter side
    input wire logic sample_valid_in,
    input wire logic conv_start_out,
    input wire logic conv_run_out,
    input wire logic [NCH-1:0] level_shift_en_out,
    input wire logic [1:0] cell_decim_out,
    input wire logic [1:0] temp_decim_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [4:0] dly_reg;
    logic trig_wr;
    logic blank_rd;
    assign trig_wr = wr_in && addr_in == ADR_TRIGGER;
    assign blank_rd = rd_in && (addr_in == ADR_TRIGGER || addr_in >= ADR_RES_END
        || (addr_in > ADR_TCOEF && addr_in < ADR_RES_BASE));
    // Only a zero delay gives a start on the very next edge.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            dly_reg <= DELAY_RST;
        else if (wr_in && addr_in == ADR_DELAY)
            dly_reg <= wr_data_in[4:0];
    end
    sequence trig_now;
        trig_wr && wr_data_in[TRIG_BIT] && dly_reg == 5'h00;
    endsequence
    sequence started;
        conv_start_out && conv_run_out;
    endsequence
    chk_trig_starts:
        assert property (trig_now |=> started) else $error("trigger gave no start");
    chk_start_runs:
        assert property (conv_start_out |-> conv_run_out) else $error("start without run");
    chk_run_rise:
        assert property ($rose(conv_run_out) |-> conv_start_out) else $error("run rose alone");
    chk_run_fall:
        assert property ($fell(conv_run_out) |-> $past(sample_valid_in) || $past(trig_wr))
        else $error("run fell without cause");
    chk_rd_idle:
        assert property (!$past(rd_in) |-> rd_data_out == 8'h00) else $error("read data not idle");
    chk_blank_reads:
        assert property (blank_rd |=> rd_data_out == 8'h00) else $error("blank read not zero");
    chk_status_active:
        assert property (rd_in && addr_in == ADR_STATUS |=> rd_data_out[ACTIVE_BIT] == $past(conv_run_out))
        else $error("status active bit wrong");
    chk_decim_pair:
        assert property (cell_decim_out == temp_decim_out) else $error("decimation mismatch");
    chk_enable_hold:
        assert property ($changed(level_shift_en_out) |-> $past(wr_in) && $past(addr_in) == ADR_CHAN_EN)
        else $error("enables changed alone");
    chk_decim_hold:
        assert property ($changed(cell_decim_out) |-> $past(wr_in) && $past(addr_in) == ADR_CONFIG_A)
        else $error("decimation changed alone");
endmodule : cal_top_sva
bind cal_top cal_top_sva #(.DLY_STEP(DLY_STEP), .INT_STEP(INT_STEP)) u_sva (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .sample_valid_in(sample_valid_in),
    .conv_start_out(conv_start_out), .conv_run_out(conv_run_out),
    .level_shift_en_out(level_shift_en_out), .cell_decim_out(cell_decim_out),
    .temp_decim_out(temp_decim_out)
);
`default_nettype wire

// >>> tb/cal_top_tb.sv
// Purpose: Self-checking register-level bench of the cell converter control block.
// Assumes: Short delay and interval steps; the bench answers each start after five cycles.
// Notes: Tally is read in the interval gap so start or end counting both match.
`timescale 1ns/100ps
`default_nettype none
module cal_top_tb import cal_pkg::*;;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic sample_valid_in = 1'b0;
    logic [NCH*RAW_W-1:0] raw_sample_in = {{4{24'h123456}}, 24'hF0ABCD, 24'h123456};
    logic [CORR_W-1:0] die_temp_in = 16'h0100;
    logic [7:0] rd_data_out, rdat;
    logic conv_start_out, conv_run_out;
    logic [NCH-1:0] level_shift_en_out;
    logic [1:0] cell_decim_out, temp_decim_out;
    int n_fail = 0, n_compared = 0, cyc = 0, rcnt = 0, n_samp = 0, base, i;
    cal_top #(.DLY_STEP(4), .INT_STEP(8)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .sample_valid_in(sample_valid_in), .raw_sample_in(raw_sample_in),
        .die_temp_in(die_temp_in), .conv_start_out(conv_start_out), .conv_run_out(conv_run_out),
        .level_shift_en_out(level_shift_en_out), .cell_decim_out(cell_decim_out),
        .temp_decim_out(temp_decim_out)
    );
    always #2 clk_in = ~clk_in;
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    // Converter stand-in: finishes a set five cycles after each start.
    always @(posedge clk_in)
    begin
        if (conv_start_out === 1'b1)
            rcnt <= 5;
        else if (rcnt != 0)
            rcnt <= rcnt - 1;
        sample_valid_in <= (rcnt == 1);
        if (sample_valid_in && conv_run_out === 1'b1)
            n_samp <= n_samp + 1;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr
    task automatic rdx(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rdat = rd_data_out;
    endtask : rdx
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rdx(a);
        chk(rdat, exp);
    endtask : rd
    task automatic wait_samp;
        for (int k = 0; k < 60; k++)
        begin
            @(posedge clk_in);
            #1;
            if (sample_valid_in === 1'b1)
                return;
        end
        chk(8'h00, 8'hFF);
    endtask : wait_samp
    function automatic logic [7:0] ra(input int ch, input logic [2:0] ofs);
        return ADR_RES_BASE + 8'(ch * 8) + {5'h00, ofs};
    endfunction : ra
    initial
    begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(ADR_CONFIG_A, CONFIG_A_RST);
        rd(ADR_STATUS, 8'h00);
        rd(ra(0, OFS_H), 8'h80);
        rd(ra(0, OFS_MU), 8'h00);
        rd(8'h0A, 8'h00);
        wr(ADR_CONFIG_A, 8'h02);
        wr(ADR_CHAN_EN, 8'h3B);
        chk({6'h00, cell_decim_out}, 8'h02);
        chk({2'h0, level_shift_en_out}, 8'h3B);
        wr(ADR_TRIGGER, 8'h01);
        chk({6'h00, conv_start_out, conv_run_out}, 8'h03);
        rd(ADR_STATUS, 8'h01);
        rd(ra(0, OFS_H), 8'h80);
        wait_samp();
        repeat (2) @(posedge clk_in);
        rd(ADR_STATUS, 8'h02);
        rd(ra(0, OFS_H), 8'h12);
        rd(ra(0, OFS_L), 8'h34);
        rd(ra(0, OFS_HF), 8'h09);
        rd(ra(0, OFS_LF), 8'h1A);
        rd(ra(0, OFS_HU), 8'h12);
        rd(ra(0, OFS_MU), 8'h34);
        rd(ra(0, OFS_LU), 8'h56);
        rd(ra(1, OFS_H), 8'hF0);
        rd(ra(2, OFS_HU), 8'h80);
        wr(ADR_TCOEF, 8'h10);
        rd(ra(0, OFS_H), 8'h12);
        wr(ADR_TRIGGER, 8'h01);
        wait_samp();
        repeat (2) @(posedge clk_in);
        rd(ra(0, OFS_L), 8'h34);
        rd(ra(0, OFS_H), 8'h12);
        rd(ra(0, OFS_L), 8'h35);
        wr(ADR_DELAY, 8'h03);
        wr(ADR_TRIGGER, 8'h01);
        for (i = 1; i < 40 && conv_start_out !== 1'b1; i++)
            @(posedge clk_in) #1;
        chk(8'((i >= 12 && i <= 14) ? 1 : 0), 8'h01);
        wait_samp();
        wr(ADR_DELAY, 8'h00);
        wr(ADR_TRIGGER, 8'h01);
        wr(ADR_TRIGGER, 8'h01);
        chk({6'h00, conv_start_out, conv_run_out}, 8'h03);
        wait_samp();
        wr(ADR_CONFIG_B, 8'h01);
        base = n_samp;
        wr(ADR_TRIGGER, 8'h01);
        repeat (3) wait_samp();
        wr(ADR_CONFIG_A, 8'h01);
        wr(ADR_CHAN_EN, 8'h00);
        chk({4'h0, cell_decim_out, level_shift_en_out[1:0]}, 8'h0B);
        wait_samp();
        repeat (2) @(posedge clk_in);
        rd(ADR_TALLY_H, 8'(((n_samp - base) >> 8) & 8'h3F));
        rd(ADR_TALLY_L, 8'((n_samp - base) & 8'hFF));
        rdx(ADR_STATUS);
        chk(rdat & 8'h02, 8'h02);
        wr(ADR_CONFIG_B, 8'h00);
        wr(ADR_TRIGGER, 8'h01);
        wait_samp();
        i = 0;
        repeat (40)
        begin
            @(posedge clk_in);
            #1;
            if (conv_start_out === 1'b1)
                i++;
        end
        chk(8'(i), 8'h00);
        rd(ADR_STATUS, 8'h02);
        wr(ADR_CONFIG_A, 8'h01);
        chk({6'h00, temp_decim_out}, 8'h01);
        wr(ADR_CONFIG_A, 8'h05);
        wr(ADR_DIAG, 8'h03);
        wr(ADR_CHAN_EN, 8'h3F);
        repeat (8) @(posedge clk_in);
        wr(ADR_TRIGGER, 8'h01);
        wait_samp();
        repeat (2) @(posedge clk_in);
        rd(ra(2, OFS_HU), 8'h04);
        rd(ra(2, OFS_MU), 8'h8D);
        rd(ra(2, OFS_LU), 8'h15);
        rd(ra(2, OFS_HF), 8'h04);
        rd(ra(2, OFS_LF), 8'h8D);
        rst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(ra(2, OFS_HU), 8'h80);
        wrap_up();
    end
endmodule : cal_top_tb
`default_nettype wire
